// ---- hdl/io_line_unit.sv ----
// I/O line unit: line options, sampling, received line passing, PWM outputs.
// Assumes a command decoder feeding cmd_t words, a framer draining sample words,
// and the radio delivering decoded I/O packets on clk_sys.
// Notes on behaviour
// - input-only line: disabled or digital input
// - line seven: flow, input, outputs, transmit enables
// - line six: flow, input, outputs; no converter
// - line five: indicator blinks, converter, input, outputs
// - lines zero-four: converter, input, outputs
// - forward received I/O data framed when enabled
// - collect configured sample count before sending
// - force sample returns inputs, else error
// - command sets levels of output lines
// - queued samples go before change data
// - periodic sampling at millisecond interval
// - only bound sender may change outputs
// - line timeout restores default level
// - shared timeout zeroes remotely set PWM
// - PWM pin function: off, signal strength, PWM
// - 10-bit readable writable PWM level
// - signal-strength duty per packet, timer shutoff
`timescale 1ns/1ps
`include "io_line_map.svh"

module io_line_unit
    import io_line_pkg::*;
#(
    parameter int unsigned MS_CYCLES     = `TICK_MS_US * `CLK_MHZ,
    parameter int unsigned HUNDRED_CYCLES = `TICK_100MS_US * `CLK_MHZ
)(
    input  wire logic            clk_sys,
    input  wire logic            nrst,
    input  wire logic            cmd_valid,
    output logic                 cmd_ready,
    input  wire cmd_t            cmd,
    output logic                 rsp_valid,
    output rsp_t                 rsp,
    input  wire logic            rx_valid,
    input  wire rx_pkt_t         rx_pkt,
    output logic                 smp_valid,
    input  wire logic            smp_ready,
    output sample_t              smp,
    input  wire logic [8:0]      line_in,
    output logic [7:0]           line_out,
    output logic [7:0]           line_oe,
    input  wire logic [5:0][9:0] adc_in,
    input  wire logic            associated,
    input  wire logic            rx_room,
    input  wire logic            uart_tx_busy,
    output logic                 host_may_send,
    output logic [1:0]           pwm_pin
);

    line_cfg_t        cfg_q [9];
    logic             fwd_q;
    logic [7:0]       samples_q;
    logic [7:0]       chg_mask_q;
    logic [15:0]      interval_q;
    logic [63:0]      bound_q;
    logic [7:0]       tmo_q [8];
    logic [1:0]       pwm_fn_q [2];
    logic [9:0]       pwm_lvl_q [2];
    logic [7:0]       pwm_tmo_q;
    logic [7:0]       rssi_tmr_set_q;
    logic [8:0]       sync1_q;
    logic [8:0]       sync2_q;
    logic [8:0]       prev_q;
    logic [31:0]      ms_cnt_q;
    logic [31:0]      hms_cnt_q;
    logic             tick_ms;
    logic             tick_hms;
    logic [15:0]      per_cnt_q;
    logic [7:0]       batch_q;
    logic             force_p_q;
    logic             chg_p_q;
    logic             per_p_q;
    logic             rem_p_q;
    logic [8:0]       chg_din_q;
    sample_t          rem_word_q;
    logic [7:0]       lvl_q;
    logic [7:0]       tmr_q [8];
    logic [7:0]       run_q;
    logic [7:0]       pwm_tmr_q;
    logic [1:0]       pwm_rem_q;
    logic [7:0]       rssi_q;
    logic [7:0]       rssi_tmr_q;
    logic             blink_q;
    logic [9:0]       pwm_cnt_q;
    logic             wr_ok;
    logic             opt_ok;
    logic [8:0]       din_en;
    logic [5:0]       adc_en;
    logic [7:0]       do_en;
    logic [7:0]       dflt;
    logic [8:0]       chg_hit;
    logic             bound_ok;
    logic             in_valid;
    logic             in_ready;
    sample_t          in_word;
    sample_t          buf_q [2];
    logic             wr_ptr_q;
    logic             rd_ptr_q;
    logic [1:0]       count_q;

    // Option legality per line
    function automatic logic opt_legal(input logic [3:0] line, input line_cfg_t v);
        logic ok;
        ok = 1'b0;
        case (line)
            4'h8: ok = (v == `CFG_DISABLED) || (v == `CFG_DI);
            4'h7: ok = (v != `CFG_ADC);
            4'h6: ok = (v <= `CFG_DO_HIGH) && (v != `CFG_ADC);
            4'h5: ok = (v <= `CFG_DO_HIGH);
            default: ok = (v <= `CFG_DO_HIGH) && (v != `CFG_SPECIAL);
        endcase
        return ok;
    endfunction : opt_legal

    always_comb
    begin
        for (int i = 0; i < 9; i++)
            din_en[i] = (cfg_q[i] == `CFG_DI);
        for (int i = 0; i < 6; i++)
            adc_en[i] = (cfg_q[i] == `CFG_ADC);
        for (int i = 0; i < 8; i++)
        begin
            do_en[i] = (cfg_q[i] == `CFG_DO_LOW) || (cfg_q[i] == `CFG_DO_HIGH);
            dflt[i]  = (cfg_q[i] == `CFG_DO_HIGH);
        end
    end

    // Command decode; every command is answered one cycle later
    assign cmd_ready = 1'b1;

    // Option values are judged on writes only; reads of known registers answer, except ID_DOUT and a force with no inputs enabled
    always_comb
    begin
        opt_ok = 1'b1;
        if (cmd.wr && (cmd.id <= `ID_INPUT_ONLY))
            opt_ok = opt_legal(cmd.id[3:0], cmd.data[2:0]) && (cmd.data[63:3] == '0);
        else if (cmd.wr && (cmd.id == `ID_SAMPLES))
            opt_ok = (cmd.data[7:0] != 8'h00);
        else if (cmd.wr && ((cmd.id == `ID_PWM_A_FN) || (cmd.id == `ID_PWM_B_FN)))
            opt_ok = (cmd.data[1:0] <= `PWM_FN_MAX);
        else if (cmd.id == `ID_FORCE)
            opt_ok = (din_en != '0) || (adc_en != '0);
        else if (cmd.id > `ID_RSSI_TIMER)
            opt_ok = 1'b0;
    end

    assign wr_ok = cmd_valid && cmd.wr && opt_ok;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < 9; i++)
                cfg_q[i] <= `RST_LINE_CFG;
            cfg_q[5] <= `RST_LINE_FIVE;
            cfg_q[7] <= `RST_LINE_SEVEN;
            fwd_q <= `RST_FWD;
            samples_q <= `RST_SAMPLES;
            chg_mask_q <= '0;
            interval_q <= '0;
            bound_q <= `RST_BOUND;
            for (int i = 0; i < 8; i++)
                tmo_q[i] <= `RST_TIMEOUT;
            pwm_fn_q[0] <= `RST_PWM_A_FN;
            pwm_fn_q[1] <= `RST_PWM_B_FN;
            pwm_tmo_q <= `RST_TIMEOUT;
            rssi_tmr_set_q <= `RST_RSSI_TIMER;
        end
        else if (wr_ok)
        begin
            if (cmd.id <= `ID_INPUT_ONLY)
                cfg_q[cmd.id[3:0]] <= cmd.data[2:0];
            else if ((cmd.id >= `ID_TIMEOUT0) && (cmd.id <= `ID_TIMEOUT7))
                tmo_q[cmd.id[2:0]] <= cmd.data[7:0];
            case (cmd.id)
                `ID_FWD:         fwd_q <= cmd.data[0];
                `ID_SAMPLES:     samples_q <= cmd.data[7:0];
                `ID_CHG_MASK:    chg_mask_q <= cmd.data[7:0];
                `ID_INTERVAL:    interval_q <= cmd.data[15:0];
                `ID_BOUND:       bound_q <= cmd.data;
                `ID_PWM_A_FN:    pwm_fn_q[0] <= cmd.data[1:0];
                `ID_PWM_B_FN:    pwm_fn_q[1] <= cmd.data[1:0];
                `ID_PWM_TIMEOUT: pwm_tmo_q <= cmd.data[7:0];
                `ID_RSSI_TIMER:  rssi_tmr_set_q <= cmd.data[7:0];
                default:         ;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            rsp_valid <= 1'b0;
            rsp <= '0;
        end
        else
        begin
            rsp_valid <= cmd_valid;
            rsp.err <= !opt_ok || (!cmd.wr && (cmd.id == `ID_DOUT));
            rsp.data <= '0;
            if (cmd.id <= `ID_INPUT_ONLY)
                rsp.data[2:0] <= cfg_q[cmd.id[3:0]];
            else if ((cmd.id >= `ID_TIMEOUT0) && (cmd.id <= `ID_TIMEOUT7))
                rsp.data[7:0] <= tmo_q[cmd.id[2:0]];
            case (cmd.id)
                `ID_FWD:         rsp.data[0] <= fwd_q;
                `ID_SAMPLES:     rsp.data[7:0] <= samples_q;
                `ID_FORCE:       rsp.data[8:0] <= sync2_q;
                `ID_CHG_MASK:    rsp.data[7:0] <= chg_mask_q;
                `ID_INTERVAL:    rsp.data[15:0] <= interval_q;
                `ID_BOUND:       rsp.data <= bound_q;
                `ID_PWM_A_FN:    rsp.data[1:0] <= pwm_fn_q[0];
                `ID_PWM_B_FN:    rsp.data[1:0] <= pwm_fn_q[1];
                `ID_PWM_A_LVL:   rsp.data[9:0] <= pwm_lvl_q[0];
                `ID_PWM_B_LVL:   rsp.data[9:0] <= pwm_lvl_q[1];
                `ID_PWM_TIMEOUT: rsp.data[7:0] <= pwm_tmo_q;
                `ID_RSSI_TIMER:  rsp.data[7:0] <= rssi_tmr_set_q;
                default:         ;
            endcase
        end
    end

    // Pin synchroniser and time bases
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
        end
        else
        begin
            sync1_q <= line_in;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    assign tick_ms  = (ms_cnt_q == MS_CYCLES - 1);
    assign tick_hms = (hms_cnt_q == HUNDRED_CYCLES - 1);

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            ms_cnt_q <= '0;
            hms_cnt_q <= '0;
            blink_q <= 1'b0;
        end
        else
        begin
            ms_cnt_q <= tick_ms ? '0 : ms_cnt_q + 32'd1;
            hms_cnt_q <= tick_hms ? '0 : hms_cnt_q + 32'd1;
            if (tick_hms)
                blink_q <= !blink_q;
        end
    end

    // Sampling triggers; a set in the same cycle as the take keeps the trigger pending
    assign chg_hit  = {1'b0, chg_mask_q} & din_en & (sync2_q ^ prev_q);
    assign bound_ok = (bound_q != `RST_BOUND)
                   && ((bound_q == `BOUND_ANY) || (rx_pkt.src == bound_q));

    always_comb
    begin
        in_word = '0;
        in_word.din_en = din_en;
        in_word.din = sync2_q & din_en;
        in_word.adc_en = adc_en;
        for (int i = 0; i < 6; i++)
            in_word.adc[i] = adc_en[i] ? adc_in[i] : 10'h000;
        in_valid = 1'b1;
        if (force_p_q)
        begin
            in_word.kind = SMP_FORCED;
            in_word.last = 1'b1;
        end
        else if (chg_p_q)
        begin
            in_word.kind = SMP_CHANGE;
            in_word.last = 1'b1;
            in_word.din = chg_din_q;
            in_word.adc_en = '0;
            in_word.adc = '0;
        end
        else if (per_p_q)
        begin
            in_word.kind = SMP_PERIODIC;
            in_word.last = (batch_q == samples_q - 8'h01);
        end
        else if (rem_p_q)
            in_word = rem_word_q;
        else
            in_valid = 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            force_p_q <= 1'b0;
            chg_p_q <= 1'b0;
            per_p_q <= 1'b0;
            rem_p_q <= 1'b0;
            chg_din_q <= '0;
            rem_word_q <= '0;
            per_cnt_q <= '0;
            batch_q <= '0;
        end
        else
        begin
            if (in_valid && in_ready)
            begin
                if (force_p_q)
                    force_p_q <= 1'b0;
                else if (chg_p_q)
                begin
                    chg_p_q <= 1'b0;
                    batch_q <= '0;
                end
                else if (per_p_q)
                begin
                    per_p_q <= 1'b0;
                    batch_q <= in_word.last ? 8'h00 : batch_q + 8'h01;
                end
                else
                    rem_p_q <= 1'b0;
            end
            if (cmd_valid && (cmd.id == `ID_FORCE) && opt_ok)
                force_p_q <= 1'b1;
            if (chg_hit != '0)
            begin
                chg_p_q <= 1'b1;
                chg_din_q <= sync2_q & din_en;
            end
            if (interval_q == 16'h0000)
                per_cnt_q <= '0;
            else if (tick_ms)
            begin
                if (per_cnt_q >= interval_q - 16'h0001)
                begin
                    per_cnt_q <= '0;
                    per_p_q <= 1'b1;
                end
                else
                    per_cnt_q <= per_cnt_q + 16'h0001;
            end
            if (rx_valid && fwd_q)
            begin
                rem_p_q <= 1'b1;
                rem_word_q <= '{kind: SMP_REMOTE, last: 1'b1, din_en: {1'b0, rx_pkt.dmask},
                                din: {1'b0, rx_pkt.dlvl}, adc_en: '0, adc: '0};
            end
        end
    end

    // Two-entry buffer; a full buffer holds the triggers pending
    assign in_ready  = (count_q != 2'd2);
    assign smp_valid = (count_q != 2'd0);
    assign smp       = buf_q[rd_ptr_q];

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            buf_q[0] <= '0;
            buf_q[1] <= '0;
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= '0;
        end
        else
        begin
            if (in_valid && in_ready)
            begin
                buf_q[wr_ptr_q] <= in_word;
                wr_ptr_q <= !wr_ptr_q;
            end
            if (smp_valid && smp_ready)
                rd_ptr_q <= !rd_ptr_q;
            count_q <= count_q + 2'(in_valid && in_ready) - 2'(smp_valid && smp_ready);
        end
    end

    // Output levels: default per option, set by command or bound sender
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            lvl_q <= '0;
            run_q <= '0;
            for (int i = 0; i < 8; i++)
                tmr_q[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                if (wr_ok && (cmd.id == 5'(i)))
                begin
                    lvl_q[i] <= (cmd.data[2:0] == `CFG_DO_HIGH);
                    run_q[i] <= 1'b0;
                end
                else if (wr_ok && (cmd.id == `ID_DOUT) && do_en[i])
                    lvl_q[i] <= cmd.data[i];
                else if (rx_valid && bound_ok)
                begin
                    if (rx_pkt.dmask[i] && do_en[i])
                    begin
                        lvl_q[i] <= rx_pkt.dlvl[i];
                        run_q[i] <= (rx_pkt.dlvl[i] != dflt[i]) && (tmo_q[i] != 8'h00);
                    end
                    tmr_q[i] <= tmo_q[i];
                end
                else if (tick_hms && run_q[i])
                begin
                    tmr_q[i] <= tmr_q[i] - 8'h01;
                    if (tmr_q[i] <= 8'h01)
                    begin
                        lvl_q[i] <= dflt[i];
                        run_q[i] <= 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            line_out <= '0;
            line_oe <= '0;
            host_may_send <= 1'b0;
        end
        else
        begin
            line_out <= lvl_q;
            line_oe <= do_en;
            if (cfg_q[5] == `CFG_SPECIAL)
            begin
                line_out[5] <= associated && blink_q;
                line_oe[5] <= 1'b1;
            end
            host_may_send <= (cfg_q[6] != `CFG_SPECIAL) || !sync2_q[6];
            case (cfg_q[7])
                `CFG_SPECIAL:
                begin
                    line_out[7] <= !rx_room;
                    line_oe[7] <= 1'b1;
                end
                `CFG_TXEN_LOW:
                begin
                    line_out[7] <= !uart_tx_busy;
                    line_oe[7] <= 1'b1;
                end
                `CFG_TXEN_HIGH:
                begin
                    line_out[7] <= uart_tx_busy;
                    line_oe[7] <= 1'b1;
                end
                default: ;
            endcase
        end
    end

    // PWM levels, shared remote timeout, signal-strength display
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            pwm_lvl_q[0] <= '0;
            pwm_lvl_q[1] <= '0;
            pwm_rem_q <= '0;
            pwm_tmr_q <= '0;
            rssi_q <= '0;
            rssi_tmr_q <= '0;
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                if (wr_ok && (cmd.id == `ID_PWM_A_LVL + 5'(c)))
                begin
                    pwm_lvl_q[c] <= cmd.data[9:0];
                    pwm_rem_q[c] <= 1'b0;
                end
                else if (rx_valid && bound_ok && rx_pkt.pwm_set[c])
                begin
                    pwm_lvl_q[c] <= rx_pkt.pwm_lvl[c];
                    pwm_rem_q[c] <= (rx_pkt.pwm_lvl[c] != 10'h000);
                end
                else if (tick_hms && pwm_rem_q[c] && (pwm_tmr_q <= 8'h01))
                begin
                    pwm_lvl_q[c] <= '0;
                    pwm_rem_q[c] <= 1'b0;
                end
            end
            if (rx_valid && bound_ok)
                pwm_tmr_q <= pwm_tmo_q;
            else if (tick_hms && (pwm_tmr_q != 8'h00))
                pwm_tmr_q <= pwm_tmr_q - 8'h01;
            if (rx_valid)
            begin
                rssi_q <= rx_pkt.rssi;
                rssi_tmr_q <= rssi_tmr_set_q;
            end
            else if (tick_hms && (rssi_tmr_q != 8'h00))
                rssi_tmr_q <= rssi_tmr_q - 8'h01;
        end
    end

    // Free-running period shared by both pins keeps them phase aligned
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            pwm_cnt_q <= '0;
            pwm_pin <= '0;
        end
        else
        begin
            pwm_cnt_q <= pwm_cnt_q + 10'h001;
            for (int c = 0; c < 2; c++)
            begin
                case (pwm_fn_q[c])
                    `PWM_FN_OUT:  pwm_pin[c] <= (pwm_cnt_q < pwm_lvl_q[c]);
                    `PWM_FN_RSSI: pwm_pin[c] <= (rssi_tmr_q != 8'h00)
                                             && (pwm_cnt_q < {rssi_q, 2'b00});
                    default:      pwm_pin[c] <= 1'b0;
                endcase
            end
        end
    end

endmodule : io_line_unit

// ---- hdl/io_line_map.svh ----
// Register identifiers, option codes, reset values and timing figures of the I/O line unit.
// Assumes inclusion by the design file, the checker and the bench; definitions only.
`ifndef IO_LINE_MAP_SVH
`define IO_LINE_MAP_SVH

`define CFG_DISABLED    3'h0
`define CFG_SPECIAL     3'h1
`define CFG_ADC         3'h2
`define CFG_DI          3'h3
`define CFG_DO_LOW      3'h4
`define CFG_DO_HIGH     3'h5
`define CFG_TXEN_LOW    3'h6
`define CFG_TXEN_HIGH   3'h7

`define ID_LINE_FIVE    5'h05
`define ID_LINE_SIX     5'h06
`define ID_LINE_SEVEN   5'h07
`define ID_INPUT_ONLY   5'h08
`define ID_FWD          5'h09
`define ID_SAMPLES      5'h0a
`define ID_FORCE        5'h0b
`define ID_DOUT         5'h0c
`define ID_CHG_MASK     5'h0d
`define ID_INTERVAL     5'h0e
`define ID_BOUND        5'h0f
`define ID_TIMEOUT0     5'h10
`define ID_TIMEOUT7     5'h17
`define ID_PWM_A_FN     5'h18
`define ID_PWM_B_FN     5'h19
`define ID_PWM_A_LVL    5'h1a
`define ID_PWM_B_LVL    5'h1b
`define ID_PWM_TIMEOUT  5'h1c
`define ID_RSSI_TIMER   5'h1d

`define RST_LINE_CFG    3'h0
`define RST_LINE_FIVE   3'h1
`define RST_LINE_SEVEN  3'h1
`define RST_FWD         1'b1
`define RST_SAMPLES     8'h01
`define RST_TIMEOUT     8'hff
`define RST_PWM_A_FN    2'h1
`define RST_PWM_B_FN    2'h0
`define RST_RSSI_TIMER  8'h28
`define RST_BOUND       64'hffffffffffffffff
`define BOUND_ANY       64'h000000000000ffff
`define PWM_FN_RSSI     2'h1
`define PWM_FN_OUT      2'h2
`define PWM_FN_MAX      2'h2

`define CLK_MHZ         100
`define TICK_MS_US      1000
`define TICK_100MS_US   100000

`endif

// ---- hdl/io_line_pkg.sv ----
// Types shared by the I/O line unit and its surroundings.
// Assumes the constant header io_line_map.svh is on the include path.
package io_line_pkg;

    typedef logic [2:0] line_cfg_t;

    typedef enum logic [1:0] {
        SMP_PERIODIC = 2'h0,
        SMP_FORCED   = 2'h1,
        SMP_CHANGE   = 2'h2,
        SMP_REMOTE   = 2'h3
    } smp_kind_t;

    typedef struct packed {
        logic        wr;
        logic [4:0]  id;
        logic [63:0] data;
    } cmd_t;

    typedef struct packed {
        logic        err;
        logic [63:0] data;
    } rsp_t;

    typedef struct packed {
        logic [63:0]     src;
        logic [7:0]      dmask;
        logic [7:0]      dlvl;
        logic [1:0]      pwm_set;
        logic [1:0][9:0] pwm_lvl;
        logic [7:0]      rssi;
    } rx_pkt_t;

    typedef struct packed {
        smp_kind_t       kind;
        logic            last;
        logic [8:0]      din_en;
        logic [8:0]      din;
        logic [5:0]      adc_en;
        logic [5:0][9:0] adc;
    } sample_t;

endpackage : io_line_pkg

// ---- verification/io_line_props.sv ----
// Checker of the I/O line unit command answers and sample hand-off.
// Assumes a bind onto io_line_unit; sees its ports only.
`timescale 1ns/1ps
`include "io_line_map.svh"
module io_line_props
    import io_line_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic cmd_valid,
    input wire cmd_t cmd,
    input wire logic rsp_valid,
    input wire rsp_t rsp,
    input wire logic smp_valid,
    input wire logic smp_ready
);
    wire       wr  = cmd_valid && cmd.wr;
    wire [2:0] opt = cmd.data[2:0];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    chk_rsp_one_cycle: assert property (1 |=> rsp_valid == $past(cmd_valid))
        else $error("answer not one cycle after command");
    chk_dout_read: assert property (cmd_valid && !cmd.wr && cmd.id == `ID_DOUT |=> rsp.err)
        else $error("read of output levels accepted");
    chk_bad_id: assert property (cmd_valid && cmd.id > `ID_RSSI_TIMER |=> rsp.err)
        else $error("unknown register accepted");
    chk_zero_count: assert property (wr && cmd.id == `ID_SAMPLES && cmd.data[7:0] == 8'h0
        |=> rsp.err) else $error("zero sample count accepted");
    chk_pwm_fn_range: assert property (wr && cmd.id == `ID_PWM_A_FN && opt[1:0] == 2'h3
        |=> rsp.err) else $error("pwm function 3 accepted");
    chk_input_only: assert property (wr && cmd.id == `ID_INPUT_ONLY && opt != `CFG_DISABLED
        && opt != `CFG_DI |=> rsp.err) else $error("input-only option accepted");
    chk_no_adc_six: assert property (wr && (cmd.id == `ID_LINE_SIX || cmd.id == `ID_LINE_SEVEN)
        && opt == `CFG_ADC |=> rsp.err) else $error("converter on six or seven");
    chk_low_special: assert property (wr && cmd.id < `ID_LINE_FIVE && opt == `CFG_SPECIAL
        |=> rsp.err) else $error("option 1 on low line accepted");
    chk_smp_hold: assert property (smp_valid && !smp_ready |=> smp_valid)
        else $error("sample word dropped while stalled");
endmodule : io_line_props
bind io_line_unit io_line_props io_line_props_inst (.clk_sys, .nrst, .cmd_valid, .cmd,
    .rsp_valid, .rsp, .smp_valid, .smp_ready);

// ---- verification/framer_model.sv ----
// Framer model: drains sample words, stalling STALL cycles after each.
// Assumes the unit's sample stream on the same clock.
`timescale 1ns/1ps
module framer_model
    import io_line_pkg::*;
#(
    parameter int STALL = 3
)(
    input  wire logic    clk_sys,
    input  wire logic    nrst,
    input  wire logic    smp_valid,
    output logic         smp_ready,
    input  wire sample_t smp,
    output sample_t      last_word,
    output int           words
);
    int wait_q;
    assign smp_ready = nrst && wait_q == 0;
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            wait_q <= STALL;
            words  <= 0;
        end
        else if (smp_valid && smp_ready)
        begin
            last_word <= smp;
            words     <= words + 1;
            wait_q    <= STALL;
        end
        else if (wait_q != 0)
            wait_q <= wait_q - 1;
    end
endmodule : framer_model

// ---- verification/io_line_unit_tb_top.sv ----
// Bench of the I/O line unit: command sequences with expected answers.
// Assumes the unit and framer_model; small tick parameters keep the run short.
`timescale 1ns/1ps
`include "io_line_map.svh"
module io_line_unit_tb_top
    import io_line_pkg::*;
;
    logic clk_sys = 0, nrst = 0, cmd_valid = 0, rx_valid = 0, cmd_ready, rsp_valid;
    logic smp_valid, smp_ready, host_may_send, busy = 0, assoc = 0;
    cmd_t cmd = '0;
    rsp_t rsp;
    rx_pkt_t rx_pkt = '0;
    sample_t smp, last_word;
    logic [8:0] line_in = 9'h001;
    logic [7:0] line_out, line_oe;
    logic [1:0] pwm_pin;
    logic [63:0] rd;
    int words, n, fail_count = 0, checks = 0;
    logic [4:0] bad_id[8] = '{5'h08, 5'h07, 5'h06, 5'h00, 5'h0a, 5'h18, 5'h1e, 5'h02};
    logic [2:0] bad_dat[8] = '{3'h1, 3'h2, 3'h2, 3'h1, 3'h0, 3'h3, 3'h0, 3'h1};
    logic [4:0] rst_id[15] = '{5'h08, 5'h07, 5'h06, 5'h05, 5'h00, 5'h09, 5'h0a, 5'h0d,
        5'h0e, 5'h0f, 5'h10, 5'h18, 5'h19, 5'h1c, 5'h1d};
    logic [63:0] rst_val[15] = '{64'h0, 64'h1, 64'h0, 64'h1, 64'h0, 64'h1, 64'h1, 64'h0,
        64'h0, 64'hffffffffffffffff, 64'hff, 64'h1, 64'h0, 64'hff, 64'h28};
    logic [2:0] ok7[7] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    always #5 clk_sys = ~clk_sys;
    io_line_unit #(.MS_CYCLES(10), .HUNDRED_CYCLES(50)) io_line_unit_inst (.clk_sys, .nrst,
        .cmd_valid, .cmd_ready, .cmd, .rsp_valid, .rsp, .rx_valid, .rx_pkt, .smp_valid,
        .smp_ready, .smp, .line_in, .line_out, .line_oe, .adc_in('0), .associated(assoc),
        .rx_room(1'b1), .uart_tx_busy(busy), .host_may_send, .pwm_pin);
    framer_model framer_model_inst (.clk_sys, .nrst, .smp_valid, .smp_ready, .smp,
        .last_word, .words);
    task check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task finish_test;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test
    task op(input logic wr, input logic [4:0] id, input logic [63:0] data, input logic err);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd <= '{wr, id, data};
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        #1 rd = rsp.data;
        check(rsp.err, err);
    endtask : op
    // Bounded wait for the framer to take one more word
    task wait_word;
        for (int k = 0; k < 60 && words == n; k++) @(posedge clk_sys);
        check(words, n + 1);
        if (words == n) finish_test;
        n = words;
        #1;
    endtask : wait_word
    task rx_send;
        @(posedge clk_sys);
        rx_valid <= 1'b1;
        rx_pkt <= '{64'h5, 8'h02, 8'h02, 2'h0, '0, 8'h30};
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        wait_word();
    endtask : rx_send
    initial
    begin
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        foreach (bad_id[i]) op(1, bad_id[i], bad_dat[i], 1);
        op(0, `ID_DOUT, 0, 1);
        foreach (rst_id[i])
        begin
            op(0, rst_id[i], 0, 0);
            check(rd, rst_val[i]);
        end
        $display("reset and refusal test done");
        foreach (ok7[i])
        begin
            op(1, `ID_LINE_SEVEN, ok7[i], 0);
            op(0, `ID_LINE_SEVEN, 0, 0);
            check(rd, ok7[i]);
        end
        @(posedge clk_sys);
        busy <= 1'b1;
        assoc <= 1'b1;
        for (int k = 0; k < 120 && !line_out[5]; k++) @(posedge clk_sys);
        check(line_out[5] && line_oe[5], 1'b1);
        check(line_out[7] && line_oe[7], 1'b1);
        check(host_may_send, 1'b1);
        op(1, `ID_PWM_A_LVL, 10'h3ff, 0);
        op(0, `ID_PWM_A_LVL, 0, 0);
        check(rd, 64'h3ff);
        $display("line seven option test done");
        op(0, `ID_FORCE, 0, 1);
        op(1, 5'h00, `CFG_DI, 0);
        n = words;
        op(0, `ID_FORCE, 0, 0);
        wait_word();
        check(last_word.kind, SMP_FORCED);
        check(last_word.din[0], 1'b1);
        $display("force sample test done");
        op(1, 5'h01, `CFG_DO_HIGH, 0);
        repeat (3) @(posedge clk_sys);
        check(line_out[1] && line_oe[1], 1'b1);
        op(1, `ID_DOUT, 0, 0);
        repeat (3) @(posedge clk_sys);
        check(line_out[1], 1'b0);
        rx_send();
        check(line_out[1], 1'b0);
        op(1, `ID_BOUND, 64'hffff, 0);
        rx_send();
        check(line_out[1], 1'b1);
        check(last_word.kind, SMP_REMOTE);
        for (int k = 0; k < 1100 && !pwm_pin[0]; k++) @(posedge clk_sys);
        check(pwm_pin[0], 1'b1);
        check(pwm_pin[1], 1'b0);
        repeat (100) @(posedge clk_sys);
        check(words, 3);
        $display("output and remote test done");
        finish_test();
    end
endmodule : io_line_unit_tb_top
